//--- include/branch_regs.svh
// Constants of the conditional branch unit: widths, register offsets,
// field positions, reset values and cycle counts.
// Assumes inclusion by bare name from the package and the design files.
`ifndef BRANCH_REGS_SVH
`define BRANCH_REGS_SVH

// Datapath widths
`define BR_PC_W          16
`define BR_OFF_W         7
`define BR_OP_W          4
`define BR_ADDR_W        4
`define BR_DATA_W        16

// Register offsets on the plain register port
`define BR_REG_CTRL      4'h0
`define BR_REG_STATUS    4'h1
`define BR_REG_TAKEN     4'h2
`define BR_REG_FALL      4'h3
`define BR_REG_TARGET    4'h4
`define BR_REG_LASTOP    4'h5
`define BR_REG_ILLEGAL   4'h6

// Control register fields
`define BR_CTRL_CNT_EN   0
`define BR_CTRL_CNT_CLR  1
`define BR_CTRL_RESET    16'h0001

// Status register fields
`define BR_STAT_BUSY     0
`define BR_STAT_TAKEN    1
`define BR_STAT_ILLEGAL  2

// Cycles per branch, counted from acceptance to completion
`define BR_CYC_FALL      1
`define BR_CYC_TAKEN     2

`endif

//--- include/branch_pkg.sv
// Types of the conditional branch unit: branch codes, sequencer states
// and the packed state record of the top module.
// Assumes branch_regs.svh on the include path.
`include "branch_regs.svh"

package branch_pkg;

	// Branch kinds presented by the instruction decoder
	typedef enum logic [`BR_OP_W-1:0] {
		branch_zero_set             = 4'h0,
		branch_nonzero              = 4'h1,
		branch_carry_set            = 4'h2,
		branch_carry_clear          = 4'h3,
		branch_unsigned_higher_same = 4'h4,
		branch_unsigned_lower       = 4'h5,
		branch_negative             = 4'h6,
		branch_positive             = 4'h7,
		branch_signed_ge            = 4'h8,
		branch_signed_lt            = 4'h9,
		branch_halfcarry_set        = 4'ha,
		branch_halfcarry_clear      = 4'hb,
		branch_transfer_set         = 4'hc,
		branch_transfer_clear       = 4'hd,
		branch_overflow_set         = 4'he
	} branch_op_t;

	// Sequencer: idle, or second cycle of a taken branch
	typedef enum logic {
		seq_idle  = 1'b0,
		seq_taken = 1'b1
	} seq_state_t;

	// Whole state of the top module
	typedef struct packed {
		seq_state_t               state;
		logic                     pc_load;
		logic [`BR_PC_W-1:0]      pc_target;
		logic                     done;
		logic                     stall;
		logic                     flags_write;
		logic                     last_taken;
		logic                     illegal;
		logic [`BR_DATA_W-1:0]    ctrl;
		logic [`BR_DATA_W-1:0]    taken_cnt;
		logic [`BR_DATA_W-1:0]    fall_cnt;
		logic [`BR_DATA_W-1:0]    illegal_cnt;
		logic [`BR_PC_W-1:0]      last_target;
		logic [`BR_OP_W-1:0]      last_op;
		logic [`BR_DATA_W-1:0]    rdata;
	} branch_state_t;

endpackage

//--- rtl/branch_cond.sv
// Condition evaluator: decides from the branch kind and the status
// flags whether a conditional branch is taken.
// Assumes flags come from the status register on the same clock.
`include "branch_regs.svh"

module branch_cond (
	// Branch kind
	input  wire logic [`BR_OP_W-1:0] op,
	// Status flags
	input  wire logic                flag_c,
	input  wire logic                flag_z,
	input  wire logic                flag_n,
	input  wire logic                flag_v,
	input  wire logic                flag_h,
	input  wire logic                flag_t,
	// Result
	output logic                     taken,
	output logic                     legal
);

	// One flag test per kind; the unused code never branches
	always_comb begin
		taken = 1'b0;
		legal = 1'b1;
		unique case (op)
			branch_pkg::branch_zero_set:             taken = flag_z;
			branch_pkg::branch_nonzero:              taken = ~flag_z;          // [RQ1]
			branch_pkg::branch_carry_set:            taken = flag_c;           // [RQ2]
			branch_pkg::branch_unsigned_lower:       taken = flag_c;           // [RQ2]
			branch_pkg::branch_carry_clear:          taken = ~flag_c;          // [RQ4]
			branch_pkg::branch_unsigned_higher_same: taken = ~flag_c;          // [RQ3]
			branch_pkg::branch_negative:             taken = flag_n;           // [RQ5]
			branch_pkg::branch_positive:             taken = ~flag_n;          // [RQ5]
			branch_pkg::branch_signed_ge:            taken = ~(flag_n ^ flag_v); // [RQ6]
			branch_pkg::branch_signed_lt:            taken = flag_n ^ flag_v;  // [RQ7]
			branch_pkg::branch_halfcarry_set:        taken = flag_h;           // [RQ8]
			branch_pkg::branch_halfcarry_clear:      taken = ~flag_h;          // [RQ8]
			branch_pkg::branch_transfer_set:         taken = flag_t;           // [RQ9]
			branch_pkg::branch_transfer_clear:       taken = ~flag_t;          // [RQ10]
			branch_pkg::branch_overflow_set:         taken = flag_v;           // [RQ11]
			default: begin
				// Spare code: treated as a fall-through, reported as illegal
				taken = 1'b0;
				legal = 1'b0;
			end
		endcase
	end

endmodule

//--- rtl/conditional_branch_unit.sv
// Conditional relative branch unit of an 8-bit core: tests a status
// flag, then either falls through or loads PC + k + 1.
// Assumes the decoder gives a one-cycle request with kind, offset and PC,
// holds off while stall is high, and the flags are settled on the core clock.
//
// Contract
// [RQ1] Branch on nonzero loads PC plus offset plus one when the zero flag is clear, else falls through.
// [RQ2] Carry-set and unsigned-lower branches are taken exactly when the carry flag is one.
// [RQ3] Unsigned same-or-higher branch is taken when carry is zero, like carry-clear.
// [RQ4] Carry-clear branch is taken when carry is zero and falls through when carry is one.
// [RQ5] Minus branch is taken while negative is one, plus branch while negative is zero.
// [RQ6] Signed greater-or-equal branch is taken when negative xor overflow is zero.
// [RQ7] Signed less-than branch is taken when negative xor overflow is one.
// [RQ8] Half-carry-set branch is taken on half-carry one, half-carry-clear on zero.
// [RQ9] Transfer-set branch is taken when the transfer flag is one, else falls through.
// [RQ10] Transfer-clear branch is taken when the transfer flag is zero, else falls through.
// [RQ11] Overflow-set branch is taken when the overflow flag is one.
// [RQ12] No branch alters a flag; one cycle when not taken, two when taken.
// [RQ13] The offset is signed and sign-extended before it is added to the incremented PC.
`include "branch_regs.svh"

module conditional_branch_unit (
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	// Branch request from the decoder
	input  wire logic                  br_valid,
	input  wire logic [`BR_OP_W-1:0]   br_op,
	input  wire logic [`BR_OFF_W-1:0]  br_offset,
	input  wire logic [`BR_PC_W-1:0]   pc_cur,
	// Status flags, read only
	input  wire logic                  flag_c,
	input  wire logic                  flag_z,
	input  wire logic                  flag_n,
	input  wire logic                  flag_v,
	input  wire logic                  flag_h,
	input  wire logic                  flag_t,
	// Program counter update
	output logic                       pc_load,
	output logic [`BR_PC_W-1:0]        pc_next,
	// Sequencing back to the decoder
	output logic                       br_done,
	output logic                       br_stall,
	output logic                       flags_write,
	// Register port
	input  wire logic [`BR_ADDR_W-1:0] reg_addr,
	input  wire logic [`BR_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [`BR_DATA_W-1:0]      reg_rdata
);

	branch_pkg::branch_state_t s_q;
	branch_pkg::branch_state_t s_d;

	logic                 cond_taken;
	logic                 cond_legal;
	logic [`BR_PC_W-1:0]  offset_ext;
	logic [`BR_PC_W-1:0]  pc_inc;
	logic [`BR_PC_W-1:0]  pc_jump;
	logic                 accept;
	logic                 count_on;

	// Flag test kept apart so the sequencer stays readable
	branch_cond u_cond (
		.op     (br_op),
		.flag_c (flag_c),
		.flag_z (flag_z),
		.flag_n (flag_n),
		.flag_v (flag_v),
		.flag_h (flag_h),
		.flag_t (flag_t),
		.taken  (cond_taken),
		.legal  (cond_legal)
	);

	// Target arithmetic; wraps at the top of program space like the PC
	always_comb begin
		offset_ext = {{(`BR_PC_W-`BR_OFF_W){br_offset[`BR_OFF_W-1]}}, br_offset}; // [RQ13]
		pc_inc     = `BR_PC_W'(pc_cur + `BR_PC_W'(1));
		pc_jump    = `BR_PC_W'(pc_inc + offset_ext); // [RQ13]
	end

	// A request in the second cycle of a taken branch is ignored
	assign accept   = br_valid && (s_q.state == branch_pkg::seq_idle);
	assign count_on = s_q.ctrl[`BR_CTRL_CNT_EN];

	// Next state of the whole block
	always_comb begin
		s_d = s_q;

		// Pulses and read data last a single cycle
		s_d.pc_load     = 1'b0;
		s_d.done        = 1'b0;
		s_d.stall       = 1'b0;
		s_d.flags_write = 1'b0; // [RQ12]
		s_d.rdata       = `BR_DATA_W'(0);

		// Branch sequencer
		unique case (s_q.state)
			branch_pkg::seq_idle: begin
				if (accept) begin
					s_d.last_op    = br_op;
					s_d.last_taken = cond_taken;
					s_d.illegal    = ~cond_legal;
					if (cond_taken) begin
						// Taken: hold the target, stall one more cycle
						s_d.state     = branch_pkg::seq_taken; // [RQ12]
						s_d.stall     = 1'b1;                  // [RQ12]
						s_d.pc_target = pc_jump;               // [RQ1]
					end else begin
						// Not taken: next instruction after one cycle
						s_d.pc_load   = 1'b1;   // [RQ12]
						s_d.done      = 1'b1;   // [RQ12]
						s_d.pc_target = pc_inc; // [RQ1]
					end
				end
			end
			branch_pkg::seq_taken: begin
				// Second cycle: redirect the PC to the held target
				s_d.state       = branch_pkg::seq_idle;
				s_d.pc_load     = 1'b1;          // [RQ12]
				s_d.done        = 1'b1;          // [RQ12]
				s_d.last_target = s_q.pc_target;
			end
		endcase

		// Statistics; a clear written together with an event wins last
		if (accept && count_on) begin
			if (cond_taken) begin
				s_d.taken_cnt = `BR_DATA_W'(s_q.taken_cnt + `BR_DATA_W'(1));
			end else begin
				s_d.fall_cnt = `BR_DATA_W'(s_q.fall_cnt + `BR_DATA_W'(1));
			end
			if (!cond_legal) begin
				s_d.illegal_cnt = `BR_DATA_W'(s_q.illegal_cnt + `BR_DATA_W'(1));
			end
		end

		// Register writes
		if (reg_wr) begin
			unique case (reg_addr)
				`BR_REG_CTRL: begin
					s_d.ctrl = reg_wdata & `BR_DATA_W'(1 << `BR_CTRL_CNT_EN);
					if (reg_wdata[`BR_CTRL_CNT_CLR]) begin
						// Clear is write-one, self-clearing
						s_d.taken_cnt   = `BR_DATA_W'(0);
						s_d.fall_cnt    = `BR_DATA_W'(0);
						s_d.illegal_cnt = `BR_DATA_W'(0);
					end
				end
				default: begin
					// Other offsets are read-only; writes are dropped
				end
			endcase
		end

		// Register reads, data in the next cycle only
		if (reg_rd) begin
			unique case (reg_addr)
				`BR_REG_CTRL: s_d.rdata = s_q.ctrl;
				`BR_REG_STATUS: begin
					s_d.rdata                   = `BR_DATA_W'(0);
					s_d.rdata[`BR_STAT_BUSY]    = (s_q.state == branch_pkg::seq_taken);
					s_d.rdata[`BR_STAT_TAKEN]   = s_q.last_taken;
					s_d.rdata[`BR_STAT_ILLEGAL] = s_q.illegal;
				end
				`BR_REG_TAKEN:   s_d.rdata = s_q.taken_cnt;
				`BR_REG_FALL:    s_d.rdata = s_q.fall_cnt;
				`BR_REG_TARGET:  s_d.rdata = `BR_DATA_W'(s_q.last_target);
				`BR_REG_LASTOP:  s_d.rdata = `BR_DATA_W'(s_q.last_op);
				`BR_REG_ILLEGAL: s_d.rdata = s_q.illegal_cnt;
				default:         s_d.rdata = `BR_DATA_W'(0);
			endcase
		end
	end

	// Single state register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q.state       <= branch_pkg::seq_idle;
			s_q.pc_load     <= 1'b0;
			s_q.pc_target   <= `BR_PC_W'(0);
			s_q.done        <= 1'b0;
			s_q.stall       <= 1'b0;
			s_q.flags_write <= 1'b0;
			s_q.last_taken  <= 1'b0;
			s_q.illegal     <= 1'b0;
			s_q.ctrl        <= `BR_CTRL_RESET;
			s_q.taken_cnt   <= `BR_DATA_W'(0);
			s_q.fall_cnt    <= `BR_DATA_W'(0);
			s_q.illegal_cnt <= `BR_DATA_W'(0);
			s_q.last_target <= `BR_PC_W'(0);
			s_q.last_op     <= `BR_OP_W'(0);
			s_q.rdata       <= `BR_DATA_W'(0);
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign pc_load     = s_q.pc_load;
	assign pc_next     = s_q.pc_target;
	assign br_done     = s_q.done;
	assign br_stall    = s_q.stall;
	assign flags_write = s_q.flags_write; // [RQ12]
	assign reg_rdata   = s_q.rdata;

endmodule

//--- verif/conditional_branch_unit_assertions.sv
// Checker of the branch unit: sequencing, targets, flag writes and read data.
// Assumes a bind to conditional_branch_unit on one clock, reset active high.
module conditional_branch_unit_assertions (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst,
	// Branch request and flags
	input wire logic        br_valid,
	input wire logic [3:0]  br_op,
	input wire logic [6:0]  br_offset,
	input wire logic [15:0] pc_cur,
	input wire logic        flag_c,
	input wire logic        flag_z,
	input wire logic        flag_n,
	input wire logic        flag_v,
	// Watched outputs
	input wire logic        pc_load,
	input wire logic [15:0] pc_next,
	input wire logic        br_done,
	input wire logic        br_stall,
	input wire logic        flags_write,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Requests in the stall cycle are ignored, so they never count
	wire logic        acc = br_valid && !br_stall;
	wire logic [15:0] nxt = pc_cur + 16'h0001;
	wire logic [15:0] tgt = nxt + {{9{br_offset[6]}}, br_offset};
	// Sequencing and targets
	property p_no_flags; !flags_write; endproperty
	a_no_flags: assert property (p_no_flags) else $error("flags written");
	property p_answer; acc |=> br_done ^ br_stall; endproperty
	a_answer: assert property (p_answer) else $error("no answer one cycle on");
	property p_second; br_stall |=> pc_load && br_done && $stable(pc_next); endproperty
	a_second: assert property (p_second) else $error("taken not done in two");
	property p_load; br_done |-> pc_load; endproperty
	a_load: assert property (p_load) else $error("done without load");
	property p_fall; acc ##1 br_done |-> pc_next == $past(nxt); endproperty
	a_fall: assert property (p_fall) else $error("bad fall target");
	property p_jump; acc ##1 br_stall |-> pc_next == $past(tgt); endproperty
	a_jump: assert property (p_jump) else $error("bad taken target");
	// Conditions of selected kinds
	property p_nz; acc && br_op == branch_pkg::branch_nonzero |=> br_stall == !$past(flag_z); endproperty
	a_nz: assert property (p_nz) else $error("nonzero decision");
	property p_cs; acc && br_op == branch_pkg::branch_carry_set |=> br_stall == $past(flag_c); endproperty
	a_cs: assert property (p_cs) else $error("carry decision");
	property p_lt; acc && br_op == branch_pkg::branch_signed_lt |=> br_stall == ($past(flag_n) ^ $past(flag_v));
	endproperty
	a_lt: assert property (p_lt) else $error("signed less decision");
	// Read data only in the cycle after a read
	property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule

//--- verif/conditional_branch_unit_test.sv
// Self-checking bench of the branch unit: random flags, offsets and PCs
// for every kind, then the register port. Assumes branch_pkg compiled first.
`include "branch_regs.svh"
module conditional_branch_unit_test;
	timeunit 1ns;
	timeprecision 1ns;
	// Design ports
	logic        clk_sys = 1'b0, rst = 1'b1, br_valid = 1'b0;
	logic [3:0]  br_op = '0, reg_addr = '0;
	logic [6:0]  br_offset = '0;
	logic [15:0] pc_cur = '0, reg_wdata = '0;
	logic        flag_c = 1'b0, flag_z = 1'b0, flag_n = 1'b0, flag_v = 1'b0, flag_h = 1'b0, flag_t = 1'b0;
	logic        reg_wr = 1'b0, reg_rd = 1'b0;
	logic        pc_load, br_done, br_stall, flags_write;
	logic [15:0] pc_next, reg_rdata;
	// Bench state
	int          err_total = 0, checks_done = 0, cyc = 0, n_tk = 0, n_fl = 0;
	logic [16:0] br_q[$];
	logic [15:0] rd_q[$];
	logic        stall_was = 1'b0, rd_was = 1'b0;
	logic [15:0] tgt_last = '0;

	conditional_branch_unit dut (.*);

	always #50 clk_sys = ~clk_sys;

	// Verdict and end of run
	task automatic finish_test;
		// A result that never showed up is a mismatch too
		if (br_q.size() != 0 || rd_q.size() != 0) begin
			err_total++;
			$display("[ERR] %0t results missing %0d %0d", $time, br_q.size(), rd_q.size());
		end
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Compare of a finished branch: taken bit and target
	task automatic cmp_branch(input logic [16:0] got, input logic [16:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t branch %h expected %h", $time, got, exp);
		end
	endtask
	// Compare of read data
	task automatic cmp_read(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t read %h expected %h", $time, got, exp);
		end
	endtask
	// Decision per kind, flags packed as {t,h,v,n,z,c}; code 15 never taken
	function automatic logic taken_of(input logic [3:0] op, input logic [5:0] f);
		logic [15:0] m;
		m = {1'b0, f[3], ~f[5], f[5], ~f[4], f[4], f[2] ^ f[3], ~(f[2] ^ f[3]),
			~f[2], f[2], f[0], ~f[0], ~f[0], f[0], ~f[1], f[1]};
		return m[op];
	endfunction
	// One branch; valid stays up so fall-throughs run back to back,
	// and a poke leaves a request in the stall cycle that must be ignored
	task automatic branch(input logic [3:0] op, input bit poke);
		logic [5:0]  f;
		logic [6:0]  k;
		logic [15:0] pc;
		logic        t;
		logic [15:0] e;
		f = 6'($urandom);
		k = 7'($urandom);
		pc = 16'($urandom);
		t = taken_of(op, f);
		{flag_t, flag_h, flag_v, flag_n, flag_z, flag_c} <= f;
		br_valid <= 1'b1;
		br_op <= op;
		br_offset <= k;
		pc_cur <= pc;
		e = t ? 16'(pc + 16'h0001 + {{9{k[6]}}, k}) : 16'(pc + 16'h0001);
		br_q.push_back({t, e});
		if (t) begin
			n_tk++;
			tgt_last = e;
		end else begin
			n_fl++;
		end
		@(posedge clk_sys);
		if (t) begin
			br_valid <= poke;
			pc_cur <= ~pc;
			@(posedge clk_sys);
		end
	endtask
	// Register read, one cycle; the caller lowers the strobe at the end
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		reg_rd <= 1'b1;
		reg_addr <= a;
		rd_q.push_back(e);
		@(posedge clk_sys);
	endtask
	// Results watched mid-cycle, where outputs have settled
	always @(negedge clk_sys) begin
		if (br_done)
			cmp_branch({stall_was, pc_next}, br_q.pop_front());
		if (rd_was)
			cmp_read(reg_rdata, rd_q.pop_front());
		stall_was = br_stall;
	end
	// Read slot tracking and hang guard
	always @(posedge clk_sys) begin
		rd_was <= reg_rd;
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			finish_test;
		end
	end
	// Main sequence
	initial begin
		void'($urandom(89003));
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd(`BR_REG_CTRL, `BR_CTRL_RESET);
		reg_rd <= 1'b0;
		for (int i = 0; i < 150; i++)
			branch(4'(i % 15), i % 7 == 3);
		br_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd(`BR_REG_TAKEN, 16'(n_tk));
		rd(`BR_REG_FALL, 16'(n_fl));
		rd(`BR_REG_TARGET, tgt_last);
		rd(4'h9, 16'h0000);
		reg_rd <= 1'b0;
		reg_wr <= 1'b1;
		reg_wdata <= 16'h0003;
		reg_addr <= `BR_REG_CTRL;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		rd(`BR_REG_TAKEN, 16'h0000);
		rd(`BR_REG_CTRL, 16'h0001);
		reg_rd <= 1'b0;
		branch(4'hf, 1'b0);
		br_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd(`BR_REG_ILLEGAL, 16'h0001);
		rd(`BR_REG_STATUS, 16'h0004);
		rd(`BR_REG_LASTOP, 16'h000f);
		reg_rd <= 1'b0;
		// Counting off: a branch must leave the counters where they are
		reg_wr <= 1'b1;
		reg_wdata <= 16'h0000;
		reg_addr <= `BR_REG_CTRL;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		branch(4'h1, 1'b0);
		br_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd(`BR_REG_FALL, 16'h0001);
		rd(`BR_REG_TAKEN, 16'h0000);
		reg_rd <= 1'b0;
		repeat (3) @(posedge clk_sys);
		finish_test;
	end
endmodule

bind conditional_branch_unit conditional_branch_unit_assertions u_chk (.*);
